// File: core/seci_defines.svh
`ifndef SECI_DEFINES_SVH
`define SECI_DEFINES_SVH
`define OFS_CMD 12'h000
`define OFS_OPER 12'h004
`define OFS_EVT 12'h008
`define OFS_MASK 12'h00c
`define OFS_STAT 12'h010
`define OFS_RADDR 12'h014
`define OFS_RDATA 12'h018
`define CMD_OP_LSB 0
`define CMD_PRI_BIT 2
`define CMD_C_LSB 4
`define CMD_K_LSB 8
`define OPER_A_LSB 0
`define OPER_E_LSB 16
`define EV_LO 0
`define EV_HI 1
`define EV_USE 2
`define EV_MEM 3
`define MASK_RST 4'h0
`define INC_A_MAX 12'h3fc
`define RAM_TOP 13'h03ff
`define KEY_IDX_MAX 8'h3f
`define AES_ROUNDS 4'ha
`define RD_LAST 6'h20
`define WR_LAST 6'h1f
`define INC_LAST 6'h07
`endif

// File: core/seci_pkg.sv
package seci_pkg;
	typedef enum logic [1:0] {
		OP_INC = 2'h0,
		OP_CODEBOOK = 2'h1,
		OP_CODEBOOK_ENCRYPT_IN_PLACE = 2'h2,
		OP_CODEBOOK_ENCRYPT_XOR_DEST = 2'h3
	} op_t;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_RD = 6'h02,
		S_ENC = 6'h04,
		S_WR = 6'h08,
		S_INC = 6'h10,
		S_DONE = 6'h20
	} eng_state_t;
	typedef struct packed {
		logic busy;
		op_t op;
		logic [3:0] c;
		logic [7:0] k;
		logic [11:0] a;
		logic [11:0] e;
	} slot_t;
endpackage

// File: core/sec_ram.sv
`timescale 1ns/1ps
`default_nettype none
module sec_ram (
	input wire logic clk,
	input wire logic [9:0] addr,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:1023];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule
`default_nettype wire

// File: core/security_instr_ecb_increment.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "seci_defines.svh"
module security_instr_ecb_increment (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic IRQ,
	output logic LOW_PRIORITY_COMPLETE_EVENT,
	output logic HIGH_PRIORITY_COMPLETE_EVENT,
	output logic MISUSE_EXCEPTION,
	output logic MEMORY_ADDRESS_EXCEPTION
);
	import seci_pkg::*;

	typedef struct packed {
		eng_state_t eng;
		slot_t [1:0] slot;
		logic cur;
		logic [5:0] cnt;
		logic carry;
		logic [3:0] round;
		logic [7:0] rcon;
		logic [127:0] key;
		logic [127:0] blk;
		logic err_use;
		logic err_mem;
		logic [27:0] oper;
		logic [3:0] evt;
		logic [3:0] mask;
		logic [9:0] raddr;
		logic [7:0] status;
		logic host_port;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic [3:0] ev_pulse;
	} regs_t;

	regs_t q_reg, q_next;
	logic [9:0] ram_addr;
	logic ram_we;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;

	sec_ram u_ram (
		.clk(CLK_SYS),
		.addr(ram_addr),
		.we(ram_we),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	function automatic logic [7:0] xtime(input logic [7:0] b);
		return {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
	endfunction

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = xtime(x);
		end
		return p;
	endfunction

	// inverse as x^254, then the affine map
	function automatic logic [7:0] sbox(input logic [7:0] x);
		logic [7:0] x2, x3, x12, x15, x240, v;
		x2 = gmul(x, x);
		x3 = gmul(x2, x);
		x12 = gmul(gmul(x3, x3), gmul(x3, x3));
		x15 = gmul(x12, x3);
		x240 = gmul(x15, x15);
		x240 = gmul(x240, x240);
		x240 = gmul(x240, x240);
		x240 = gmul(x240, x240);
		v = gmul(gmul(x240, x12), x2);
		return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ 8'h63;
	endfunction

	function automatic logic [127:0] key_step(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] t, w0, w1, w2;
		t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
		w0 = k[127:96] ^ t;
		w1 = k[95:64] ^ w0;
		w2 = k[63:32] ^ w1;
		return {w0, w1, w2, k[31:0] ^ w2};
	endfunction

	function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] rk, input logic last);
		logic [127:0] t, m;
		logic [7:0] a0, a1, a2, a3;
		for (int j = 0; j < 16; j++) begin
			t[127-8*j -: 8] = sbox(s[127-8*(4*(((j/4)+(j%4))%4)+(j%4)) -: 8]);
		end
		m = t;
		for (int c = 0; c < 4; c++) begin
			a0 = t[127-32*c -: 8];
			a1 = t[119-32*c -: 8];
			a2 = t[111-32*c -: 8];
			a3 = t[103-32*c -: 8];
			if (!last) begin
				m[127-32*c -: 32] = {xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3, a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3,
					a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3, xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3)};
			end
		end
		return m ^ rk;
	endfunction

	logic sel;
	slot_t cs;
	logic [11:0] dst;
	logic [11:0] eaddr;
	logic [127:0] nk;
	logic [3:0] set;
	logic [3:0] clr;
	logic acc;
	logic host_ok;
	logic [5:0] b;
	logic [2:0] inc_len;
	logic pri;
	logic err_u;
	logic err_m;

	always_comb begin
		q_next = q_reg;
		set = 4'h0;
		clr = 4'h0;
		ram_we = 1'b0;
		ram_wdata = 8'h00;
		eaddr = {2'h0, q_reg.raddr};
		q_next.pready = 1'b0;
		q_next.pslverr = 1'b0;
		sel = (q_reg.eng == S_IDLE) ? q_reg.slot[1].busy : q_reg.cur;
		cs = q_reg.slot[sel];
		dst = (cs.op == OP_CODEBOOK_ENCRYPT_IN_PLACE) ? cs.a : cs.e;
		nk = key_step(q_reg.key, q_reg.rcon);
		b = q_reg.cnt - 6'h01;
		inc_len = 3'h1 << cs.c[1:0];
		err_u = 1'b0;
		err_m = 1'b0;
		unique case (q_reg.eng)
			S_IDLE: begin
				if (q_reg.slot[0].busy | q_reg.slot[1].busy) begin
					q_next.cur = sel;
					q_next.cnt = 6'h00;
					q_next.carry = 1'b1;
					q_next.round = 4'h0;
					q_next.rcon = 8'h01;
					if (cs.op == OP_INC) begin
						err_u = (cs.c[1:0] == 2'h3);
						err_m = !err_u && (cs.a > `INC_A_MAX);
					end else begin
						err_m = (cs.k > `KEY_IDX_MAX) || (({1'b0, cs.a} + 13'h000f - {9'h0, cs.c}) > `RAM_TOP)
							|| (({1'b0, dst} + 13'h000f) > `RAM_TOP);
					end
					q_next.err_use = err_u;
					q_next.err_mem = err_m;
					q_next.eng = (err_u | err_m) ? S_DONE : ((cs.op == OP_INC) ? S_INC : S_RD);
				end
			end
			S_RD: begin
				eaddr = ((q_reg.cnt < 6'h10) ? {cs.k, 4'h0} : cs.a) + {8'h0, q_reg.cnt[3:0]};
				if (q_reg.cnt != 6'h00) begin
					if (b < 6'h10) begin
						q_next.key[8*(15-b[3:0]) +: 8] = ram_rdata;
					end else if ({1'b0, b[3:0]} >= (5'h10 - {1'b0, cs.c})) begin
						q_next.blk[8*(15-b[3:0]) +: 8] = 8'h00;
					end else begin
						q_next.blk[8*(15-b[3:0]) +: 8] = ram_rdata;
					end
				end
				q_next.cnt = q_reg.cnt + 6'h01;
				if (q_reg.cnt == `RD_LAST) begin
					q_next.eng = S_ENC;
				end
			end
			S_ENC: begin
				if (q_reg.round == 4'h0) begin
					q_next.blk = q_reg.blk ^ q_reg.key;
				end else begin
					q_next.key = nk;
					q_next.blk = aes_round(q_reg.blk, nk, q_reg.round == `AES_ROUNDS);
					q_next.rcon = xtime(q_reg.rcon);
				end
				q_next.round = q_reg.round + 4'h1;
				q_next.cnt = 6'h00;
				if (q_reg.round == `AES_ROUNDS) begin
					q_next.eng = S_WR;
				end
			end
			S_WR: begin
				eaddr = dst + {8'h0, q_reg.cnt[4:1]};
				if (q_reg.cnt[0]) begin
					ram_we = 1'b1;
					ram_wdata = q_reg.blk[8*(15-q_reg.cnt[4:1]) +: 8]
						^ ((cs.op == OP_CODEBOOK_ENCRYPT_XOR_DEST) ? ram_rdata : 8'h00);
				end
				q_next.cnt = q_reg.cnt + 6'h01;
				if (q_reg.cnt == `WR_LAST) begin
					q_next.eng = S_DONE;
				end
			end
			S_INC: begin
				eaddr = cs.a + {10'h0, q_reg.cnt[2:1]};
				if (q_reg.cnt[0]) begin
					ram_we = 1'b1;
					ram_wdata = ram_rdata;
					if ({1'b0, q_reg.cnt[2:1]} < inc_len) begin
						ram_wdata = ram_rdata + {7'h0, q_reg.carry};
						q_next.carry = q_reg.carry & (ram_rdata == 8'hff);
					end
				end
				q_next.cnt = q_reg.cnt + 6'h01;
				if (q_reg.cnt == `INC_LAST) begin
					q_next.eng = S_DONE;
				end
			end
			S_DONE: begin
				set[q_reg.cur ? `EV_HI : `EV_LO] = 1'b1;
				set[`EV_USE] = q_reg.err_use;
				set[`EV_MEM] = q_reg.err_mem;
				q_next.slot[q_reg.cur].busy = 1'b0;
				q_next.eng = S_IDLE;
			end
		endcase
		ram_addr = eaddr[9:0];
		acc = PSEL & PENABLE & ~q_reg.pready;
		host_ok = (q_reg.eng == S_IDLE) & q_reg.host_port;
		pri = PWDATA[`CMD_PRI_BIT];
		if (acc && (PADDR != `OFS_RDATA || host_ok)) begin
			q_next.pready = 1'b1;
			q_next.prdata = 32'h0;
			if (PWRITE) begin
				unique case (PADDR)
					`OFS_CMD: begin
						q_next.status = {5'h0, ~q_reg.slot[pri].busy, q_reg.slot[1].busy, q_reg.slot[0].busy};
						if (q_reg.slot[pri].busy) begin
							set[`EV_USE] = 1'b1;
						end else begin
							q_next.slot[pri] = '{busy: 1'b1, op: op_t'(PWDATA[`CMD_OP_LSB +: 2]),
								c: PWDATA[`CMD_C_LSB +: 4], k: PWDATA[`CMD_K_LSB +: 8],
								a: q_reg.oper[`OPER_A_LSB +: 12], e: q_reg.oper[`OPER_E_LSB +: 12]};
						end
					end
					`OFS_OPER: q_next.oper = PWDATA[27:0];
					`OFS_EVT: clr = PWDATA[3:0];
					`OFS_MASK: q_next.mask = PWDATA[3:0];
					`OFS_RADDR: q_next.raddr = PWDATA[9:0];
					`OFS_STAT: begin
					end
					`OFS_RDATA: begin
						ram_we = 1'b1;
						ram_wdata = PWDATA[7:0];
					end
					default: q_next.pslverr = 1'b1;
				endcase
			end else begin
				unique case (PADDR)
					`OFS_CMD: q_next.prdata = 32'h0;
					`OFS_OPER: q_next.prdata = {4'h0, q_reg.oper};
					`OFS_EVT: q_next.prdata = {28'h0, q_reg.evt};
					`OFS_MASK: q_next.prdata = {28'h0, q_reg.mask};
					`OFS_STAT: q_next.prdata = {22'h0, q_reg.slot[1].busy, q_reg.slot[0].busy, q_reg.status};
					`OFS_RADDR: q_next.prdata = {22'h0, q_reg.raddr};
					`OFS_RDATA: q_next.prdata = {24'h0, ram_rdata};
					default: q_next.pslverr = 1'b1;
				endcase
			end
		end
		q_next.host_port = (q_reg.eng == S_IDLE);
		q_next.evt = (q_reg.evt & ~clr) | set;
		q_next.ev_pulse = set;
		q_next.irq = |(q_next.evt & q_next.mask);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			q_reg <= '0;
			q_reg.eng <= S_IDLE;
			q_reg.mask <= `MASK_RST;
		end else begin
			q_reg <= q_next;
		end
	end

	assign PRDATA = q_reg.prdata;
	assign PREADY = q_reg.pready;
	assign PSLVERR = q_reg.pslverr;
	assign IRQ = q_reg.irq;
	assign LOW_PRIORITY_COMPLETE_EVENT = q_reg.ev_pulse[`EV_LO];
	assign HIGH_PRIORITY_COMPLETE_EVENT = q_reg.ev_pulse[`EV_HI];
	assign MISUSE_EXCEPTION = q_reg.ev_pulse[`EV_USE];
	assign MEMORY_ADDRESS_EXCEPTION = q_reg.ev_pulse[`EV_MEM];

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	done_level_a: assert property ((q_reg.eng == S_DONE) |=> ## 0 (q_reg.cur ? HIGH_PRIORITY_COMPLETE_EVENT
		: LOW_PRIORITY_COMPLETE_EVENT) && q_reg.eng == S_IDLE) else $error("wrong completion event");
	busy_issue_a: assert property ((acc && PWRITE && PADDR == `OFS_CMD && q_reg.slot[pri].busy)
		|=> MISUSE_EXCEPTION && q_reg.evt[`EV_USE]) else $error("busy issue not refused");
	inc_size_a: assert property ((q_reg.eng == S_INC) |-> cs.c[1:0] != 2'h3) else $error("size three ran");
	inc_range_a: assert property ((q_reg.eng == S_INC) |-> cs.a <= `INC_A_MAX && q_reg.cnt <= `INC_LAST)
		else $error("increment out of range");
	key_addr_a: assert property ((q_reg.eng == S_RD && q_reg.cnt < 6'h10)
		|-> ram_addr == 10'(cs.k * 16 + q_reg.cnt)) else $error("bad key address");
	block_len_a: assert property ((q_reg.eng == S_ENC && q_reg.round == `AES_ROUNDS)
		|=> (q_reg.eng == S_WR) ##31 (q_reg.eng == S_WR && q_reg.cnt == `WR_LAST) ##1 (q_reg.eng == S_DONE))
		else $error("not sixteen bytes written");
	inplace_dst_a: assert property ((q_reg.eng == S_WR && cs.op == OP_CODEBOOK_ENCRYPT_IN_PLACE)
		|-> ram_addr == 10'(cs.a + q_reg.cnt[4:1])) else $error("in-place address wrong");
	irq_follow_a: assert property ($rose(q_reg.evt[`EV_MEM]) && q_reg.mask[`EV_MEM] |-> IRQ)
		else $error("interrupt missing");
	mem_fault_a: assert property ((q_reg.eng == S_DONE && q_reg.err_mem) |=> MEMORY_ADDRESS_EXCEPTION
		&& q_reg.evt[`EV_MEM]) else $error("address fault not reported");
endmodule
`default_nettype wire

// File: verification/host_apb.sv
`timescale 1ns/1ps
`default_nettype none
module host_apb (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one transfer, called just after a rising edge; holds until pready is sampled
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic to);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		q = prdata;
		e = pslverr;
		to = (n >= 200);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "seci_defines.svh"
module tb;
	import seci_pkg::*;
	logic clk, rst, psel, pen, pwr, pready, perr, irq, ev_lo, ev_hi, ev_use, ev_mem, err, to;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [7:0] q;
	int mismatches, n_compared;
	int n_mem = 0;
	localparam logic [127:0] aes_kat = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	security_instr_ecb_increment security_instr_ecb_increment_inst (.CLK_SYS(clk), .RESET(rst),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(perr), .IRQ(irq), .LOW_PRIORITY_COMPLETE_EVENT(ev_lo),
		.HIGH_PRIORITY_COMPLETE_EVENT(ev_hi), .MISUSE_EXCEPTION(ev_use), .MEMORY_ADDRESS_EXCEPTION(ev_mem));
	host_apb host_apb_inst (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// counts address fault pulses seen on the pin
	always @(posedge clk) begin
		if (ev_mem === 1'b1) begin
			n_mem <= n_mem + 1;
		end
	end
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		host_apb_inst.xfer(w, a, d, rdv, err, to);
		if (to) begin
			mismatches++;
			close_out;
		end
	endtask
	task poke(input logic [9:0] a, input logic [7:0] b);
		xf(1'b1, `OFS_RADDR, {22'h0, a});
		xf(1'b1, `OFS_RDATA, {24'h0, b});
	endtask
	task peek(input logic [9:0] a);
		xf(1'b1, `OFS_RADDR, {22'h0, a});
		xf(1'b0, `OFS_RDATA, 32'h0);
	endtask
	task issue(input op_t op, input logic p, input logic [3:0] c, input logic [7:0] k,
		input logic [11:0] a, input logic [11:0] e);
		xf(1'b1, `OFS_OPER, {4'h0, e, 4'h0, a});
		xf(1'b1, `OFS_CMD, {16'h0, k, c, 1'b0, p, op});
	endtask
	// polls the event register until the given bits are set, checks the value against exp, then clears all four event bits
	task wait_evt(input logic [3:0] m, input logic [3:0] exp);
		int n;
		n = 0;
		xf(1'b0, `OFS_EVT, 32'h0);
		while ((rdv[3:0] & m) !== m && n < 100) begin
			xf(1'b0, `OFS_EVT, 32'h0);
			n++;
		end
		if (n >= 100) begin
			mismatches++;
			close_out;
		end
		chk(rdv, {28'h0, exp});
		xf(1'b1, `OFS_EVT, 32'hf);
	endtask
	task t_reset;
		xf(1'b0, `OFS_MASK, 32'h0);
		chk(rdv, 32'h0);
		xf(1'b0, `OFS_STAT, 32'h0);
		chk(rdv, 32'h0);
		xf(1'b0, 12'h01c, 32'h0);
		chk({rdv[30:0], err}, 32'h1);
		$display("test reset done");
	endtask
	task t_inc;
		poke(10'h100, 8'hff);
		poke(10'h101, 8'hff);
		poke(10'h102, 8'h12);
		issue(OP_INC, 1'b0, 4'h1, 8'h0, 12'h100, 12'h0);
		wait_evt(4'h1, 4'h1);
		peek(10'h100);
		chk(rdv, 32'h0);
		peek(10'h101);
		chk(rdv, 32'h0);
		peek(10'h102);
		chk(rdv, 32'h12);
		issue(OP_INC, 1'b1, 4'h2, 8'h0, 12'h100, 12'h0);
		wait_evt(4'h2, 4'h2);
		peek(10'h100);
		chk(rdv, 32'h1);
		$display("test increment done");
	endtask
	task t_bad;
		xf(1'b1, `OFS_MASK, 32'h8);
		issue(OP_INC, 1'b0, 4'h3, 8'h0, 12'h100, 12'h0);
		wait_evt(4'h1, 4'h5);
		peek(10'h100);
		chk(rdv, 32'h1);
		issue(OP_INC, 1'b1, 4'h0, 8'h0, 12'h3fd, 12'h0);
		wait_evt(4'h2, 4'ha);
		poke(10'h3fc, 8'hff);
		poke(10'h3fd, 8'h00);
		issue(OP_INC, 1'b1, 4'h0, 8'h0, 12'h3fc, 12'h0);
		wait_evt(4'h2, 4'h2);
		peek(10'h3fd);
		chk(rdv, 32'h0);
		issue(OP_CODEBOOK, 1'b0, 4'h0, 8'h2, 12'h040, 12'h3f8);
		wait_evt(4'h1, 4'h9);
		chk(n_mem, 32'h2);
		$display("test faults done");
	endtask
	// known-answer block at 0x40; padded block in place at 0x80 against a zero-tailed copy at 0xa0
	task t_ecb;
		logic [9:0] i;
		logic [7:0] pt;
		int diff;
		diff = 0;
		for (i = 10'h0; i < 10'h10; i++) begin
			pt = {i[3:0], i[3:0]};
			poke(10'h20 + i, i[7:0]);
			poke(10'h40 + i, pt);
			poke(10'h80 + i, i[3] ? 8'h5a ^ i[7:0] : pt);
			poke(10'ha0 + i, i[3] ? 8'h00 : pt);
			poke(10'hc0 + i, 8'h5a ^ i[7:0]);
		end
		issue(OP_CODEBOOK, 1'b0, 4'h0, 8'h2, 12'h040, 12'h060);
		wait_evt(4'h1, 4'h1);
		issue(OP_CODEBOOK_ENCRYPT_IN_PLACE, 1'b0, 4'h8, 8'h2, 12'h080, 12'h0);
		wait_evt(4'h1, 4'h1);
		issue(OP_CODEBOOK_ENCRYPT_XOR_DEST, 1'b1, 4'h0, 8'h2, 12'h0a0, 12'h0c0);
		wait_evt(4'h2, 4'h2);
		for (i = 10'h0; i < 10'h10; i++) begin
			pt = {i[3:0], i[3:0]};
			peek(10'h60 + i);
			chk(rdv, {24'h0, aes_kat[8*(15-i[3:0]) +: 8]});
			peek(10'h80 + i);
			q = rdv[7:0];
			diff += int'(q != (i[3] ? 8'h5a ^ i[7:0] : pt));
			peek(10'hc0 + i);
			chk(rdv, {24'h0, q ^ 8'h5a ^ i[7:0]});
			peek(10'h40 + i);
			chk(rdv, {24'h0, pt});
		end
		chk(32'(diff > 8), 32'h1);
		$display("test codebook done");
	endtask
	task t_busy;
		xf(1'b1, `OFS_MASK, 32'h4);
		issue(OP_CODEBOOK, 1'b0, 4'h0, 8'h2, 12'h040, 12'h060);
		issue(OP_INC, 1'b0, 4'h0, 8'h0, 12'h100, 12'h0);
		xf(1'b0, `OFS_STAT, 32'h0);
		chk({24'h0, rdv[7:0]}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		issue(OP_INC, 1'b1, 4'h0, 8'h0, 12'h100, 12'h0);
		xf(1'b0, `OFS_STAT, 32'h0);
		chk({24'h0, rdv[7:0]}, 32'h5);
		wait_evt(4'h3, 4'h7);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		peek(10'h100);
		chk(rdv, 32'h2);
		$display("test busy done");
	endtask
	initial begin
		rst = 1'b1;
		mismatches = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_inc;
		t_bad;
		t_ecb;
		t_busy;
		close_out;
	end
endmodule
`default_nettype wire
